/* ism_pkg.sv */
// Constants and types shared by the serial bus master port.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
`default_nettype none

package ism_pkg;

  // System clock rate and the two serial clock rates.
  localparam int CLK_HZ = 50_000_000;
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;

  // Quarter of one serial clock period in system clocks, rounded down.
  localparam int QTR_STD = CLK_HZ / (4 * SCL_STD_HZ);
  localparam int QTR_FAST = CLK_HZ / (4 * SCL_FAST_HZ);

  // Width of the quarter-period counter.
  localparam int CNT_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TXD = 8'h04;
  localparam logic [7:0] OFS_RXD = 8'h08;
  localparam logic [7:0] OFS_EVT = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Bit positions in the status and control register.
  localparam int B_STOP_WR = 0;
  localparam int B_STOP_RD = 1;
  localparam int B_TX_IEN = 2;
  localparam int B_TX_EMPTY = 3;
  localparam int B_FAST = 4;
  localparam int B_ERR = 5;
  localparam int B_RX_IEN = 6;
  localparam int B_RX_FULL = 7;

  // Reset value of the status and control register.
  localparam logic [7:0] CTRL_RST = 8'h08;

  // Bit positions in the event status and mask registers.
  localparam int EVT_W = 3;
  localparam int E_TX_EMPTY = 0;
  localparam int E_RX_FULL = 1;
  localparam int E_ERR = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

  // Register selected by an address.
  typedef enum logic [2:0] {R_CTRL, R_TXD, R_RXD, R_EVT, R_MASK, R_NONE} ism_reg_t;

  // Phases of the serial byte engine.
  typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_HOLD, S_STOP} ism_state_t;

  // Maps a byte address onto a register.
  function automatic ism_reg_t ism_decode(input logic [7:0] addr);
    unique case (addr)
      OFS_CTRL: ism_decode = R_CTRL;
      OFS_TXD: ism_decode = R_TXD;
      OFS_RXD: ism_decode = R_RXD;
      OFS_EVT: ism_decode = R_EVT;
      OFS_MASK: ism_decode = R_MASK;
      default: ism_decode = R_NONE;
    endcase
  endfunction : ism_decode

endpackage : ism_pkg

`default_nettype wire

/* ism_eng_if.sv */
// Carrier between the register block and the serial byte engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none

interface ism_eng_if;
  logic cmd_valid; // A byte command is waiting.
  logic cmd_rd; // The waiting command receives rather than sends.
  logic cmd_stop; // A stop condition follows the byte.
  logic [7:0] cmd_data; // Byte to send.
  logic fast; // Selects the fast serial clock.
  logic loaded; // Pulse: the command entered the shift register.
  logic ld_rd; // The command in the shift register is a receive.
  logic done; // Pulse: the byte and its acknowledge slot are over.
  logic nack; // The slave did not acknowledge the last sent byte.
  logic [7:0] rx_data; // Shift register contents.

  // Register block side.
  modport ctl (output cmd_valid, cmd_rd, cmd_stop, cmd_data, fast,
    input loaded, ld_rd, done, nack, rx_data);

  // Engine side.
  modport eng (input cmd_valid, cmd_rd, cmd_stop, cmd_data, fast,
    output loaded, ld_rd, done, nack, rx_data);
endinterface : ism_eng_if

`default_nettype wire

/* ism_engine.sv */
// Serial byte engine: start, eight data bits, acknowledge slot, stop.
// Assumes open-drain pins resolved outside; the pin inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module ism_engine
  import ism_pkg::*;
#(
  parameter int QTR_SLOW = QTR_STD,
  parameter int QTR_HIGH = QTR_FAST
) (
  input wire logic pclk,
  input wire logic presetn,
  ism_eng_if.eng bus,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe
);

  // The counter must hold the reload and a quarter needs a few cycles.
  if (QTR_SLOW < 4 || QTR_SLOW > 255 || QTR_HIGH < 4 || QTR_HIGH > 255) begin : g_bad
    $error("ism_engine: quarter period out of range");
  end

  localparam logic [CNT_W-1:0] RLD_SLOW = CNT_W'(QTR_SLOW - 1);
  localparam logic [CNT_W-1:0] RLD_HIGH = CNT_W'(QTR_HIGH - 1);

  // Whole state of the engine.
  typedef struct packed {
    ism_state_t state;
    logic [1:0] q; // Quarter within the current bit.
    logic [CNT_W-1:0] cnt; // Free-running quarter counter.
    logic [3:0] bitn; // Bit index, 8 is the acknowledge slot.
    logic [7:0] shreg; // Serial data shift register.
    logic rd;
    logic stop;
    logic nack;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_oe;
    logic sda_oe;
    logic loaded;
    logic done;
  } ism_eng_st_t;

  localparam ism_eng_st_t ENG_RST = '{state: S_IDLE, default: '0};

  ism_eng_st_t st_r; // Registered state.
  ism_eng_st_t st_nxt; // Next state.
  logic tick; // One quarter period has passed.
  logic adv; // The phase may move on; waits while a slave holds SCL low.
  logic byte_end; // Last quarter of the acknowledge slot.

  assign tick = (st_r.cnt == '0);
  assign adv = tick && !((st_r.state == S_BIT || st_r.state == S_STOP) &&
    st_r.q == 2'h2 && !st_r.scl_s2);
  assign byte_end = adv && st_r.state == S_BIT && st_r.q == 2'h3 && st_r.bitn == 4'h8;

  // Next-state logic; the counter never restarts so quarters stay even.
  always_comb begin
    st_nxt = st_r;
    st_nxt.loaded = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.scl_s1 = scl_i;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.sda_s1 = sda_i;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.cnt = tick ? (bus.fast ? RLD_HIGH : RLD_SLOW) : st_r.cnt - 1'b1;
    unique case (st_r.state)
      S_IDLE, S_HOLD: begin
        // A waiting byte enters the shift register; idle bus needs a start first.
        if (bus.cmd_valid) begin
          st_nxt.shreg = bus.cmd_data;
          st_nxt.rd = bus.cmd_rd;
          st_nxt.stop = bus.cmd_stop;
          st_nxt.nack = 1'b0;
          st_nxt.loaded = 1'b1;
          st_nxt.bitn = 4'h0;
          st_nxt.q = 2'h0;
          st_nxt.state = (st_r.state == S_IDLE) ? S_START : S_BIT;
        end
      end
      S_START: begin
        // SDA falls while SCL is high, then SCL falls.
        if (adv) begin
          st_nxt.q = st_r.q + 2'h1;
          if (st_r.q == 2'h0) begin
            st_nxt.sda_oe = 1'b1;
          end else if (st_r.q == 2'h1) begin
            st_nxt.scl_oe = 1'b1;
          end else begin
            st_nxt.q = 2'h0;
            st_nxt.state = S_BIT;
          end
        end
      end
      S_BIT: begin
        if (adv) begin
          st_nxt.q = st_r.q + 2'h1;
          unique case (st_r.q)
            2'h0: begin
              // SCL is low: set up data, or the acknowledge on a receive.
              if (st_r.bitn != 4'h8) begin
                st_nxt.sda_oe = !st_r.rd && !st_r.shreg[7];
              end else begin
                st_nxt.sda_oe = st_r.rd && !st_r.stop;
              end
            end
            2'h1: st_nxt.scl_oe = 1'b0;
            2'h2: begin
              // SCL is seen high: sample the line.
              if (st_r.bitn != 4'h8) begin
                st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s2};
              end else if (!st_r.rd) begin
                st_nxt.nack = st_r.sda_s2;
              end
            end
            2'h3: begin
              st_nxt.scl_oe = 1'b1;
              st_nxt.q = 2'h0;
              st_nxt.bitn = st_r.bitn + 4'h1;
              if (st_r.bitn == 4'h8) begin
                st_nxt.done = 1'b1;
                // A refused byte always ends the transfer.
                if (st_r.stop || (!st_r.rd && st_r.nack)) begin
                  st_nxt.state = S_STOP;
                end else begin
                  st_nxt.state = S_HOLD;
                end
              end
            end
          endcase
        end
      end
      S_STOP: begin
        // SDA low, SCL released, then SDA released while SCL is high.
        if (adv) begin
          st_nxt.q = st_r.q + 2'h1;
          unique case (st_r.q)
            2'h0: st_nxt.sda_oe = 1'b1;
            2'h1: st_nxt.scl_oe = 1'b0;
            2'h2: st_nxt.sda_oe = 1'b0;
            2'h3: begin
              st_nxt.q = 2'h0;
              st_nxt.state = S_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ENG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.loaded = st_r.loaded;
  assign bus.ld_rd = st_r.rd;
  assign bus.done = st_r.done;
  assign bus.nack = st_r.nack;
  assign bus.rx_data = st_r.shreg;
  assign scl_oe = st_r.scl_oe;
  assign sda_oe = st_r.sda_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The stop runs to a released, idle bus.
  sequence s_stop_run;
    st_r.state == S_STOP ##[1:1000] (st_r.state == S_IDLE && !st_r.sda_oe && !st_r.scl_oe);
  endsequence

  a_write_stop: assert property (byte_end && !st_r.rd && st_r.stop |=> s_stop_run)
    else $error("no stop after sent byte");
  a_read_stop: assert property (byte_end && st_r.rd && st_r.stop |=> s_stop_run)
    else $error("no stop after received byte");
  a_no_stop: assert property (byte_end && !st_r.stop && !(!st_r.rd && st_r.nack)
    |=> st_r.state == S_HOLD && st_r.scl_oe)
    else $error("unexpected stop after byte");
  a_idle_start: assert property (st_r.state == S_IDLE && bus.cmd_valid
    |=> st_r.state == S_START && st_r.loaded)
    else $error("written byte did not start a transfer");
  a_fast_quarter: assert property (tick && bus.fast |-> ##31 tick)
    else $error("fast quarter period wrong");
  a_slow_quarter: assert property (tick && !bus.fast |-> ##125 tick)
    else $error("slow quarter period wrong");

endmodule : ism_engine

`default_nettype wire

/* ism_top.sv */
// Serial bus master port: APB registers, handshake flags, interrupt.
// Assumes an APB master on pclk and open-drain SCL and SDA wires outside.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module ism_top
  import ism_pkg::*;
#(
  parameter int QTR_SLOW = QTR_STD,
  parameter int QTR_HIGH = QTR_FAST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  // Whole state of the register block.
  typedef struct packed {
    logic stop_wr; // Stop after a sent byte.
    logic stop_rd; // Stop after a received byte.
    logic tx_ien; // Transmit empty interrupt enable.
    logic tx_empty_flag; // Transmit holding byte is free.
    logic fast; // 400 kHz when set.
    logic err; // Slave did not acknowledge.
    logic rx_ien; // Receive ready interrupt enable.
    logic rx_full_flag; // Received byte waits to be read.
    logic [7:0] tx_data; // Transmit holding byte.
    logic [7:0] rx_data; // Last received byte.
    logic rd_req; // Software asked for one byte to be received.
    logic tx_wr_d; // A transmit write landed in the previous cycle.
    logic rx_req_d; // A receive request landed in the previous cycle.
    logic [EVT_W-1:0] evt; // Sticky events, cleared by reading.
    logic [EVT_W-1:0] mask; // Event interrupt mask.
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } ism_top_st_t;

  localparam ism_top_st_t TOP_RST = '{tx_empty_flag: CTRL_RST[B_TX_EMPTY], evt: EVT_RST,
    mask: EVT_RST, default: '0};

  ism_top_st_t st_r; // Registered state.
  ism_top_st_t st_nxt; // Next state.
  ism_reg_t sel; // Register under the current address.
  logic setup_acc; // First access cycle: read data is captured.
  logic done_acc; // Handshake cycle: writes and read side effects land.
  logic tx_wr; // Software writes the transmit byte now.
  logic rx_req_wr; // Software asks for a receive now.
  logic tx_taken; // A sent byte left the holding register and no write replaced it.

  ism_eng_if eng_bus ();

  // Packs the status and control register.
  function automatic logic [7:0] ctrl_byte(input ism_top_st_t s);
    logic [7:0] v;
    v = 8'h00;
    v[B_STOP_WR] = s.stop_wr;
    v[B_STOP_RD] = s.stop_rd;
    v[B_TX_IEN] = s.tx_ien;
    v[B_TX_EMPTY] = s.tx_empty_flag;
    v[B_FAST] = s.fast;
    v[B_ERR] = s.err;
    v[B_RX_IEN] = s.rx_ien;
    v[B_RX_FULL] = s.rx_full_flag;
    return v;
  endfunction : ctrl_byte

  // Interrupt level for a given state.
  function automatic logic irq_of(input ism_top_st_t s);
    return (s.tx_empty_flag && s.tx_ien) || (s.rx_full_flag && s.rx_ien) ||
      |(s.evt & s.mask);
  endfunction : irq_of

  assign sel = ism_decode(paddr);
  assign setup_acc = psel && penable && !st_r.pready;
  assign done_acc = psel && penable && st_r.pready;
  assign tx_wr = done_acc && pwrite && sel == R_TXD;
  assign rx_req_wr = done_acc && pwrite && sel == R_RXD;
  assign tx_taken = eng_bus.loaded && !eng_bus.ld_rd && !tx_wr && !st_r.tx_wr_d;

  // A held transmit byte goes before a receive request.
  assign eng_bus.cmd_valid = !st_r.tx_empty_flag || st_r.rd_req;
  assign eng_bus.cmd_rd = st_r.tx_empty_flag;
  assign eng_bus.cmd_stop = st_r.tx_empty_flag ? st_r.stop_rd : st_r.stop_wr;
  assign eng_bus.cmd_data = st_r.tx_data;
  assign eng_bus.fast = st_r.fast;

  // Next-state logic: bus answer, software effects, then hardware events.
  // Hardware events come last so that a set beats a clear in the same cycle, except for tx_empty_flag, where a write wins.
  always_comb begin
    st_nxt = st_r;
    // One wait state: pready rises in the second access cycle.
    st_nxt.pready = setup_acc;
    st_nxt.pslverr = setup_acc && sel == R_NONE;
    if (setup_acc) begin
      unique case (sel)
        R_CTRL: st_nxt.prdata = {24'h000000, ctrl_byte(st_r)};
        R_RXD: st_nxt.prdata = {24'h000000, st_r.rx_data};
        R_EVT: st_nxt.prdata = {29'h00000000, st_r.evt};
        R_MASK: st_nxt.prdata = {29'h00000000, st_r.mask};
        R_TXD, R_NONE: st_nxt.prdata = 32'h00000000;
      endcase
      if (pwrite) begin
        st_nxt.prdata = 32'h00000000;
      end
    end
    // Register writes at the handshake edge.
    if (done_acc && pwrite) begin
      unique case (sel)
        R_CTRL: begin
          st_nxt.stop_wr = pwdata[B_STOP_WR];
          st_nxt.stop_rd = pwdata[B_STOP_RD];
          st_nxt.tx_ien = pwdata[B_TX_IEN];
          st_nxt.fast = pwdata[B_FAST];
          st_nxt.rx_ien = pwdata[B_RX_IEN];
          if (pwdata[B_ERR]) begin
            st_nxt.err = 1'b0;
          end
        end
        R_TXD: begin
          // A write while full replaces the held byte.
          st_nxt.tx_data = pwdata[7:0];
          st_nxt.tx_empty_flag = 1'b0;
        end
        R_RXD: st_nxt.rd_req = 1'b1;
        R_MASK: st_nxt.mask = pwdata[EVT_W-1:0];
        R_EVT, R_NONE: begin
        end
      endcase
    end
    // Read side effects; only the event bits that were shown are cleared.
    if (done_acc && !pwrite) begin
      if (sel == R_RXD) begin
        st_nxt.rx_full_flag = 1'b0;
      end
      if (sel == R_EVT) begin
        st_nxt.evt = st_r.evt & ~st_r.prdata[EVT_W-1:0];
      end
    end
    // Engine events. A write in the cycle the engine took the old byte, or in the
    // cycle after, leaves a new byte held, so the empty flag must stay clear.
    if (tx_taken) begin
      st_nxt.tx_empty_flag = 1'b1;
    end
    // The same holds for a receive request that meets the loading of an earlier one.
    if (eng_bus.loaded && eng_bus.ld_rd && !rx_req_wr && !st_r.rx_req_d) begin
      st_nxt.rd_req = 1'b0;
    end
    if (eng_bus.done && eng_bus.ld_rd) begin
      st_nxt.rx_data = eng_bus.rx_data;
      st_nxt.rx_full_flag = 1'b1;
    end
    if (eng_bus.done && eng_bus.nack) begin
      st_nxt.err = 1'b1;
    end
    st_nxt.tx_wr_d = tx_wr;
    st_nxt.rx_req_d = rx_req_wr;
    st_nxt.evt[E_TX_EMPTY] = st_nxt.evt[E_TX_EMPTY] || (eng_bus.loaded && !eng_bus.ld_rd);
    st_nxt.evt[E_RX_FULL] = st_nxt.evt[E_RX_FULL] || (eng_bus.done && eng_bus.ld_rd);
    st_nxt.evt[E_ERR] = st_nxt.evt[E_ERR] || (eng_bus.done && eng_bus.nack);
    st_nxt.irq = irq_of(st_nxt);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Serial byte engine; it owns the pin synchronisers.
  ism_engine #(
    .QTR_SLOW(QTR_SLOW),
    .QTR_HIGH(QTR_HIGH)
  ) u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .bus(eng_bus),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign irq = st_r.irq;
  // Open-drain pins only ever pull low.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_empty_write_clear: assert property (tx_wr |=> !st_r.tx_empty_flag)
    else $error("transmit empty not cleared by write");
  a_empty_load_set: assert property (tx_taken |=> st_r.tx_empty_flag)
    else $error("transmit empty not set on load");
  a_empty_poll: assert property (setup_acc && !pwrite && sel == R_CTRL
    |=> pready && prdata[B_TX_EMPTY] == $past(st_r.tx_empty_flag))
    else $error("status read shows wrong empty flag");
  a_tx_irq: assert property (st_r.tx_empty_flag && st_r.tx_ien |-> irq)
    else $error("transmit interrupt missing");
  a_irq_quiet: assert property (!(st_r.tx_empty_flag && st_r.tx_ien) &&
    !(st_r.rx_full_flag && st_r.rx_ien) && (st_r.evt & st_r.mask) == '0 |-> !irq)
    else $error("interrupt without enabled cause");
  a_rx_irq: assert property (st_r.rx_full_flag && st_r.rx_ien |-> irq)
    else $error("receive interrupt missing");
  a_err_set: assert property (eng_bus.done && eng_bus.nack |=> st_r.err)
    else $error("error flag not set on refusal");
  a_err_w1c: assert property (done_acc && pwrite && sel == R_CTRL && pwdata[B_ERR] &&
    !(eng_bus.done && eng_bus.nack) |=> !st_r.err)
    else $error("error flag not cleared by write of one");

endmodule : ism_top

`default_nettype wire

/* ism_slave_model.sv */
// Behavioural serial slave that stands on the far side of the master port.
// Assumes open-drain wires with pull-ups, resolved in the bench.
`timescale 1ns/100ps
`default_nettype none

module ism_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_en,
  input wire logic send_en,
  input wire logic [7:0] send_byte,
  output logic sda_pull,
  output logic [7:0] got_byte,
  output int bytes,
  output int stops
);
  int cnt = 0; // Slot within the byte; 8 is the acknowledge slot.
  logic quiet = 1'b0; // Set once the master refuses a byte, so the stop can pass.
  logic [7:0] sh = 8'h00; // Incoming bits.

  // Outputs start released so the wires idle high.
  initial begin
    sda_pull = 1'b0;
    got_byte = 8'h00;
    bytes = 0;
    stops = 0;
  end

  // A start restarts the byte count.
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    quiet = 1'b0;
  end

  // A stop is counted so the bench can see whether one followed a byte.
  always @(posedge sda) if (scl === 1'b1) begin
    cnt = 0;
    quiet = 1'b0;
    stops++;
  end

  // Data is taken on the rising clock edge, most significant bit first.
  always @(posedge scl) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt++;
    end else begin
      if (send_en && sda) quiet = 1'b1;
      got_byte = sh;
      bytes++;
      cnt = 0;
    end
  end

  // The data line only changes while the clock is low, never as a false start.
  always @(negedge scl) begin
    if (quiet) sda_pull = 1'b0;
    else if (cnt < 8) sda_pull = send_en & ~send_byte[7 - cnt];
    else sda_pull = ~send_en & ~nack_en;
  end
endmodule : ism_slave_model

`default_nettype wire

/* tb.sv */
// Self-checking bench for the serial master port with its APB registers.
// Assumes the slave model on the wires and default quarter-period counts.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end

module tb
  import ism_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, irq, scl_oe, sda_oe, sda_pull, err;
  logic nack_en = 1'b0;
  logic send_en = 1'b0;
  logic [7:0] send_byte = 8'h96;
  logic [7:0] got_byte;
  logic [31:0] prdata, rd;
  wire logic scl, sda;
  int bytes, stops, st0, by0;
  int fail_count = 0;
  int compares = 0;
  int run = 0; // Length of the current high phase of the serial clock.
  int hi_len = 0; // Length of the last finished high phase.

  // Open-drain wires: pulled up unless some party pulls them low.
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | sda_pull);

  // 50 MHz system clock.
  initial begin
    forever #10 pclk = ~pclk;
  end

  ism_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe));

  ism_slave_model u_slave (.scl(scl), .sda(sda), .nack_en(nack_en), .send_en(send_en),
    .send_byte(send_byte), .sda_pull(sda_pull), .got_byte(got_byte), .bytes(bytes),
    .stops(stops));

  // Measures serial clock high time; the idle high never ends, so it is not counted.
  always @(posedge pclk) begin
    if (scl === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run > 0) hi_len <= run;
      run <= 0;
    end
  end

  // One APB transfer; read data and error are taken at the handshake edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Lets a registered interrupt follow its cause.
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask : settle

  // Polls one status bit; a bounded count keeps a stuck flag from hanging the run.
  task automatic wait_ctrl(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CTRL, 32'h0);
      n++;
    end while (rd[b] !== v && n < 5000);
    if (n >= 5000) fail_count++;
  endtask : wait_ctrl

  // Waits for the slave to see the given number of stops.
  task automatic wait_stops(input int s);
    int n;
    n = 0;
    while (stops != s && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) fail_count++;
  endtask : wait_stops

  // Reset value, read-only bit, enables and an unmapped address.
  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl reset", rd, 32'h0000_0008)
    `CHK("irq reset", irq, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0000_00FF);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl ones", rd, 32'h0000_005F)
    settle();
    `CHK("irq tx empty", irq, 1'b1)
    apb(1'b1, OFS_CTRL, 32'h0);
    settle();
    `CHK("irq off", irq, 1'b0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", err, 1'b1)
  endtask : t_regs

  // Two bytes back to back: the first without stop, the second with one.
  task automatic t_write();
    st0 = stops;
    by0 = bytes;
    apb(1'b1, OFS_CTRL, 32'h0000_0014);
    apb(1'b1, OFS_TXD, 32'h0000_00A5);
    apb(1'b1, OFS_TXD, 32'h0000_003C);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("tx full", rd[B_TX_EMPTY], 1'b0)
    `CHK("irq full", irq, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0000_0015);
    wait_ctrl(B_TX_EMPTY, 1'b1);
    settle();
    `CHK("irq empty", irq, 1'b1)
    `CHK("byte one", got_byte, 8'hA5)
    `CHK("no stop", stops, st0)
    wait_stops(st0 + 1);
    `CHK("byte two", got_byte, 8'h3C)
    `CHK("bytes sent", bytes, by0 + 2)
    `CHK("fast high", hi_len < 100, 1'b1)
  endtask : t_write

  // Two received bytes: the first held without stop, the second ends with one.
  task automatic t_read();
    st0 = stops;
    send_en <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0000_0050);
    apb(1'b1, OFS_RXD, 32'h0);
    wait_ctrl(B_RX_FULL, 1'b1);
    repeat (200) @(posedge pclk);
    `CHK("irq rx", irq, 1'b1)
    `CHK("rd no stop", stops, st0)
    apb(1'b0, OFS_RXD, 32'h0);
    `CHK("rx one", rd, 32'h0000_0096)
    apb(1'b1, OFS_CTRL, 32'h0000_0012);
    apb(1'b1, OFS_RXD, 32'h0);
    wait_stops(st0 + 1);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("rx full", rd[B_RX_FULL], 1'b1)
    apb(1'b0, OFS_RXD, 32'h0);
    `CHK("rx two", rd[7:0], 8'h96)
    send_en <= 1'b0;
  endtask : t_read

  // Refused byte: error bit, event interrupt raised, masked and cleared.
  task automatic t_nack();
    st0 = stops;
    nack_en <= 1'b1;
    apb(1'b0, OFS_EVT, 32'h0);
    apb(1'b1, OFS_MASK, 32'h0000_0004);
    apb(1'b1, OFS_CTRL, 32'h0000_0011);
    apb(1'b1, OFS_TXD, 32'h0000_0055);
    wait_stops(st0 + 1);
    nack_en <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0000_0011);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("err kept", rd[B_ERR], 1'b1)
    `CHK("irq nack", irq, 1'b1)
    apb(1'b1, OFS_MASK, 32'h0);
    settle();
    `CHK("irq masked", irq, 1'b0)
    apb(1'b1, OFS_MASK, 32'h0000_0004);
    apb(1'b0, OFS_EVT, 32'h0);
    `CHK("nack event", rd[E_ERR], 1'b1)
    settle();
    `CHK("irq clear", irq, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0000_0031);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("err clear", rd[B_ERR], 1'b0)
  endtask : t_nack

  // One byte at the slow rate: the clock high time is about four times longer.
  task automatic t_slow();
    st0 = stops;
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, OFS_TXD, 32'h0000_00C3);
    wait_stops(st0 + 1);
    `CHK("slow high", hi_len > 150, 1'b1)
    `CHK("slow byte", got_byte, 8'hC3)
  endtask : t_slow

  // Prints the counts and the verdict, then ends the run.
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence after two cycles of reset.
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_write();
    t_read();
    t_nack();
    t_slow();
    end_of_test();
  end

  // Watchdog: the scenarios need well under a fifth of this span.
  initial begin
    #2_000_000;
    fail_count++;
    end_of_test();
  end
endmodule : tb

`default_nettype wire
